// [src/pdg_cnt_if.sv]
// Control and match signals between a sequencer and a match counter
`timescale 1ns/10ps
interface pdg_cnt_if;
	logic run;
	logic clear;
	logic [31:0] match1_val;
	logic [31:0] match2_val;
	logic [31:0] count;
	logic match1;
	logic match2;

	modport ctl(output run, clear, match1_val, match2_val,
		input count, match1, match2);
	modport cnt(input run, clear, match1_val, match2_val,
		output count, match1, match2);
endinterface

// [src/pdg_counter.sv]
// Up counter with two match thresholds and a synchronous clear
`timescale 1ns/10ps
module pdg_counter (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Counter control and matches
	pdg_cnt_if.cnt cnt
);
	logic [31:0] count_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= 32'h0;
		end else if (!cnt.run || cnt.clear) begin
			count_reg <= 32'h0;
		end else begin
			count_reg <= count_reg + 32'h1;
		end
	end

	assign cnt.count = count_reg;
	assign cnt.match1 = cnt.run && (count_reg == cnt.match1_val);
	assign cnt.match2 = cnt.run && (count_reg == cnt.match2_val);

	a_clear_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cnt.run && cnt.clear) |=> (count_reg == 32'h0))
		else $error("counter did not return to zero after clear");
	a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(cnt.run && !cnt.clear) ##1 cnt.run |->
		count_reg == $past(count_reg) + 32'h1)
		else $error("counter did not advance by one");
endmodule

// [src/pdg_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PDG_DEFS_SVH
`define PDG_DEFS_SVH

`define PDG_CLK_HZ 50000000
`define PDG_MAX_PULSE_HZ 5000000
`define PDG_MIN_PULSE_CYC ((`PDG_CLK_HZ + `PDG_MAX_PULSE_HZ - 1) / `PDG_MAX_PULSE_HZ)
`define PDG_MIN_PHASE_CYC ((`PDG_MIN_PULSE_CYC + 1) / 2)

`define PDG_OFS_CTRL 8'h00
`define PDG_OFS_NUM 8'h04
`define PDG_OFS_HIGH 8'h08
`define PDG_OFS_LOW 8'h0c
`define PDG_OFS_ACTIVE 8'h10
`define PDG_OFS_PERIOD 8'h14
`define PDG_OFS_IRQ_STAT 8'h18
`define PDG_OFS_IRQ_MASK 8'h1c
`define PDG_OFS_STATE 8'h20

`define PDG_CTRL_ENABLE 0
`define PDG_CTRL_RUN 1
`define PDG_CTRL_DIR 2
`define PDG_IRQ_PERIOD 0
`define PDG_IRQ_RELOAD 1

`define PDG_RST_NUM 16'h0004
`define PDG_RST_HIGH 16'h0019
`define PDG_RST_LOW 16'h0019
`define PDG_RST_ACTIVE 32'h0000_01f4
`define PDG_RST_PERIOD 32'h0000_03e8

`define PDG_RESP_OKAY 2'h0
`define PDG_RESP_SLVERR 2'h2

`endif

// [src/pdg_pkg.sv]
// Types shared by the pulse and direction generator
package pdg_pkg;

	typedef enum logic [1:0] {PS_IDLE, PS_HIGH, PS_LOW, PS_DONE} pdg_pulse_state_type;
	typedef enum logic [1:0] {AP_IDLE, AP_ACTIVE, AP_GAP} pdg_period_state_type;

	typedef struct packed {
		logic dir;
		logic [15:0] num;
		logic [15:0] high;
		logic [15:0] low;
		logic [31:0] active;
		logic [31:0] period;
	} pdg_cfg_type;

endpackage

// [src/pdg_pulse_shape.sv]
// Pulse shaping sequencer: alternating high and low phases, pulse count
`timescale 1ns/10ps
module pdg_pulse_shape
	import pdg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Sequencing
	input wire logic i_start,
	input wire logic i_allow,
	input wire logic [15:0] i_pulse_num,
	input wire logic [15:0] i_high_w,
	input wire logic [15:0] i_low_w,
	// Pulse width counter
	pdg_cnt_if.ctl cnt,
	// Results
	output logic o_pulse,
	output logic o_busy,
	output logic [15:0] o_emitted
);
	pdg_pulse_state_type state_reg;
	logic last_pulse;
	logic begin_pulse;
	logic high_end;
	logic low_end;

	assign last_pulse = (o_emitted + 16'h1) == i_pulse_num;
	assign begin_pulse = ((state_reg == PS_IDLE) || (state_reg == PS_DONE))
		&& i_start && (i_pulse_num != 16'h0);
	assign high_end = (state_reg == PS_HIGH) && cnt.match1;
	assign low_end = (state_reg == PS_LOW) && cnt.match2;

	// Phase ends restart the counter for the next phase
	assign cnt.run = (state_reg == PS_HIGH) || (state_reg == PS_LOW);
	assign cnt.clear = high_end || low_end;
	assign cnt.match1_val = {16'h0, i_high_w - 16'h1};
	assign cnt.match2_val = {16'h0, i_low_w - 16'h1};
	assign o_busy = cnt.run;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= PS_IDLE;
		end else if (!i_allow) begin
			state_reg <= PS_IDLE;
		end else begin
			case (state_reg)
				PS_IDLE, PS_DONE: begin
					if (begin_pulse) begin
						state_reg <= PS_HIGH;
					end
				end
				PS_HIGH: begin
					if (high_end) begin
						state_reg <= PS_LOW;
					end
				end
				PS_LOW: begin
					if (low_end) begin
						state_reg <= last_pulse ? PS_DONE : PS_HIGH;
					end
				end
				default: begin
					state_reg <= PS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pulse <= 1'b0;
		end else if (!i_allow) begin
			o_pulse <= 1'b0;
		end else if (begin_pulse || (low_end && !last_pulse)) begin
			o_pulse <= 1'b1;
		end else if (high_end || low_end) begin
			o_pulse <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_emitted <= 16'h0;
		end else if (begin_pulse) begin
			o_emitted <= 16'h0;
		end else if (i_allow && low_end) begin
			o_emitted <= o_emitted + 16'h1;
		end
	end

	a_high_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_allow && high_end) |=> !o_pulse && state_reg == PS_LOW)
		else $error("high phase did not end on first match");
	a_low_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_allow && low_end && !last_pulse) |=> o_pulse)
		else $error("low phase did not hand over to high");
	a_count_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_allow && low_end && last_pulse) |=> state_reg == PS_DONE ##1
		(!o_pulse || !$past(i_allow) || $past(i_start)))
		else $error("pulse emitted beyond configured count");
endmodule

// [src/pdg_top.sv]
// Pulse and direction generator with AXI4-Lite register access
//
// Operation
// - Pulse rate stays at or below 5 MHz; short phases are stretched.
// - The run bit starts the pulse train when set, stops when cleared.
// - The direction bit selects the level later driven on the direction pin.
// - Direction output changes only at the end of a full period; go_rise also loads it when the run starts.
// - Trigger rising edge or active period end loads settings into staging.
// - Pulse width counter: first match ends high, second ends low.
// - Pulse sequencer state picks which match restarts the width counter.
// - Period counter match one ends active period, match two full period.
// - Configured pulses during the active period, none for the remainder.
// - One start term launches period and full period counters together.
// - Full period counter match raises interrupt; wraps at period end.
// - New settings take effect only at the full period interrupt event; go_rise also loads them straight from the registers.
// - Only two outputs: pulse and direction, plus trigger and software bits. The code also drives a third output, the interrupt line O_IRQ.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "pdg_defs.svh"
module pdg_top
	import pdg_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	// External trigger
	input wire logic I_TRIGGER,
	// AXI4-Lite write address and data
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [7:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	// Drive outputs and interrupt
	output logic O_PULSE,
	output logic O_DIR,
	output logic O_IRQ
);
	localparam logic [15:0] MIN_PHASE = 16'(`PDG_MIN_PHASE_CYC);

	logic [2:0] ctrl_reg;
	logic [15:0] num_reg;
	logic [15:0] high_reg;
	logic [15:0] low_reg;
	logic [31:0] active_reg;
	logic [31:0] period_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	pdg_cfg_type sw_cfg;
	pdg_cfg_type stage_cfg_reg;
	pdg_cfg_type work_cfg_reg;
	logic dir_reg;
	logic go;
	logic go_prev_reg;
	logic go_rise;
	logic run_q;
	logic trig_prev_reg;
	logic reload_event;
	logic full_end;
	logic start;
	logic allow;
	pdg_period_state_type ap_state_reg;
	logic [15:0] high_eff;
	logic [15:0] low_eff;
	logic pulse_busy;
	logic [15:0] emitted;

	// AXI holding state
	logic aw_hold_reg;
	logic [7:0] aw_addr_reg;
	logic w_hold_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_en;
	logic wr_hit;
	logic [31:0] wmask;
	logic [31:0] rd_data;
	logic rd_hit;

	pdg_cnt_if pw_if();
	pdg_cnt_if per_if();
	pdg_cnt_if fp_if();

	// Register slave
	assign O_AXI_AWREADY = !aw_hold_reg;
	assign O_AXI_WREADY = !w_hold_reg;
	assign O_AXI_ARREADY = !O_AXI_RVALID;
	assign wr_en = aw_hold_reg && w_hold_reg && !O_AXI_BVALID;
	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	always_comb begin
		wr_hit = 1'b1;
		case ({aw_addr_reg[7:2], 2'b00})
			`PDG_OFS_CTRL, `PDG_OFS_NUM, `PDG_OFS_HIGH, `PDG_OFS_LOW,
			`PDG_OFS_ACTIVE, `PDG_OFS_PERIOD, `PDG_OFS_IRQ_STAT,
			`PDG_OFS_IRQ_MASK, `PDG_OFS_STATE: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_data = 32'h0;
		case ({I_AXI_ARADDR[7:2], 2'b00})
			`PDG_OFS_CTRL: rd_data = {29'h0, ctrl_reg};
			`PDG_OFS_NUM: rd_data = {16'h0, num_reg};
			`PDG_OFS_HIGH: rd_data = {16'h0, high_reg};
			`PDG_OFS_LOW: rd_data = {16'h0, low_reg};
			`PDG_OFS_ACTIVE: rd_data = active_reg;
			`PDG_OFS_PERIOD: rd_data = period_reg;
			`PDG_OFS_IRQ_STAT: rd_data = {30'h0, irq_status_reg};
			`PDG_OFS_IRQ_MASK: rd_data = {30'h0, irq_mask_reg};
			`PDG_OFS_STATE: rd_data = {emitted, 12'h0,
				ap_state_reg == AP_ACTIVE, pulse_busy, O_DIR, O_PULSE};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h0;
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP <= `PDG_RESP_OKAY;
		end else begin
			if (I_AXI_AWVALID && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= I_AXI_AWADDR;
			end
			if (I_AXI_WVALID && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= I_AXI_WDATA;
				w_strb_reg <= I_AXI_WSTRB;
			end
			if (wr_en) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				O_AXI_BVALID <= 1'b1;
				O_AXI_BRESP <= wr_hit ? `PDG_RESP_OKAY : `PDG_RESP_SLVERR;
			end else if (O_AXI_BVALID && I_AXI_BREADY) begin
				O_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_AXI_RVALID <= 1'b0;
			O_AXI_RDATA <= 32'h0;
			O_AXI_RRESP <= `PDG_RESP_OKAY;
		end else if (I_AXI_ARVALID && !O_AXI_RVALID) begin
			O_AXI_RVALID <= 1'b1;
			O_AXI_RDATA <= rd_data;
			O_AXI_RRESP <= rd_hit ? `PDG_RESP_OKAY : `PDG_RESP_SLVERR;
		end else if (I_AXI_RREADY) begin
			O_AXI_RVALID <= 1'b0;
		end
	end

	// Software settings, byte lanes honoured
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl_reg <= 3'h0;
			num_reg <= `PDG_RST_NUM;
			high_reg <= `PDG_RST_HIGH;
			low_reg <= `PDG_RST_LOW;
			active_reg <= `PDG_RST_ACTIVE;
			period_reg <= `PDG_RST_PERIOD;
			irq_mask_reg <= 2'h0;
		end else if (wr_en) begin
			case ({aw_addr_reg[7:2], 2'b00})
				`PDG_OFS_CTRL: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[2:0];
				`PDG_OFS_NUM: num_reg <= (num_reg & ~wmask[15:0])
					| (w_data_reg[15:0] & wmask[15:0]);
				`PDG_OFS_HIGH: high_reg <= (high_reg & ~wmask[15:0])
					| (w_data_reg[15:0] & wmask[15:0]);
				`PDG_OFS_LOW: low_reg <= (low_reg & ~wmask[15:0])
					| (w_data_reg[15:0] & wmask[15:0]);
				`PDG_OFS_ACTIVE: active_reg <= (active_reg & ~wmask)
					| (w_data_reg & wmask);
				`PDG_OFS_PERIOD: period_reg <= (period_reg & ~wmask)
					| (w_data_reg & wmask);
				`PDG_OFS_IRQ_MASK:
					if (w_strb_reg[0]) irq_mask_reg <= w_data_reg[1:0];
				default: begin
				end
			endcase
		end
	end

	// Interrupt status: a new event wins over a same-cycle clear
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_status_reg <= 2'h0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~((wr_en && w_strb_reg[0]
				&& {aw_addr_reg[7:2], 2'b00} == `PDG_OFS_IRQ_STAT)
				? w_data_reg[1:0] : 2'h0))
				| {reload_event, full_end};
		end
	end
	assign O_IRQ = |(irq_status_reg & irq_mask_reg);

	assign sw_cfg = '{dir: ctrl_reg[`PDG_CTRL_DIR], num: num_reg,
		high: high_reg, low: low_reg, active: active_reg, period: period_reg};
	assign go = ctrl_reg[`PDG_CTRL_ENABLE] && ctrl_reg[`PDG_CTRL_RUN];
	assign go_rise = go && !go_prev_reg;
	// One idle cycle after go lets the first settings settle
	assign run_q = go && go_prev_reg;
	assign reload_event = (I_TRIGGER && !trig_prev_reg) || per_if.match1;
	assign full_end = fp_if.match1;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			go_prev_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			go_prev_reg <= go;
			trig_prev_reg <= I_TRIGGER;
		end
	end

	// Staging then working copy of the settings
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			stage_cfg_reg <= '0;
			work_cfg_reg <= '0;
			dir_reg <= 1'b0;
		end else if (go_rise) begin
			stage_cfg_reg <= sw_cfg;
			work_cfg_reg <= sw_cfg;
			dir_reg <= sw_cfg.dir;
		end else begin
			if (reload_event) begin
				stage_cfg_reg <= sw_cfg;
			end
			if (full_end) begin
				work_cfg_reg <= stage_cfg_reg;
				dir_reg <= stage_cfg_reg.dir;
			end
		end
	end
	assign O_DIR = dir_reg;

	// Both period counters share one start term
	assign per_if.run = run_q;
	assign fp_if.run = run_q;
	assign per_if.clear = per_if.match2;
	assign fp_if.clear = fp_if.match2;
	assign per_if.match1_val = work_cfg_reg.active - 32'h1;
	assign per_if.match2_val = work_cfg_reg.period - 32'h1;
	assign fp_if.match1_val = work_cfg_reg.period - 32'h1;
	assign fp_if.match2_val = work_cfg_reg.period - 32'h1;

	assign start = run_q && ((ap_state_reg == AP_IDLE) || per_if.match2);
	assign allow = start || (run_q && ap_state_reg == AP_ACTIVE
		&& !per_if.match1);

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ap_state_reg <= AP_IDLE;
		end else if (!run_q) begin
			ap_state_reg <= AP_IDLE;
		end else begin
			case (ap_state_reg)
				AP_IDLE: ap_state_reg <= AP_ACTIVE;
				AP_ACTIVE: begin
					if (per_if.match2) begin
						ap_state_reg <= AP_ACTIVE;
					end else if (per_if.match1) begin
						ap_state_reg <= AP_GAP;
					end
				end
				AP_GAP: begin
					if (per_if.match2) begin
						ap_state_reg <= AP_ACTIVE;
					end
				end
				default: ap_state_reg <= AP_IDLE;
			endcase
		end
	end

	// Stretch short phases so the pulse rate never passes the limit
	assign high_eff = (work_cfg_reg.high < MIN_PHASE) ? MIN_PHASE
		: work_cfg_reg.high;
	assign low_eff = (work_cfg_reg.low < MIN_PHASE) ? MIN_PHASE
		: work_cfg_reg.low;

	pdg_counter u_per_cnt (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.cnt(per_if)
	);

	pdg_counter u_fp_cnt (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.cnt(fp_if)
	);

	pdg_counter u_pw_cnt (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.cnt(pw_if)
	);

	pdg_pulse_shape u_shape (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_start(start),
		.i_allow(allow),
		.i_pulse_num(work_cfg_reg.num),
		.i_high_w(high_eff),
		.i_low_w(low_eff),
		.cnt(pw_if),
		.o_pulse(O_PULSE),
		.o_busy(pulse_busy),
		.o_emitted(emitted)
	);

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	a_idle_low: assert property (!go |=> ##1 !O_PULSE)
		else $error("pulse active while stopped");
	a_run_starts: assert property ((ap_state_reg == AP_IDLE && run_q
		&& work_cfg_reg.num != 16'h0) |=> O_PULSE)
		else $error("run did not start the pulse train");
	a_dir_hold: assert property ($changed(dir_reg) |->
		$past(full_end) || $past(go_rise))
		else $error("direction changed inside a period");
	a_cfg_boundary: assert property ($changed(work_cfg_reg) |->
		$past(full_end) || $past(go_rise))
		else $error("settings changed inside a period");
	a_reload_load: assert property ((reload_event && !go_rise) |=>
		stage_cfg_reg == $past(sw_cfg))
		else $error("reload event did not stage settings");
	a_gap_quiet: assert property ((ap_state_reg == AP_GAP
		&& $past(ap_state_reg) == AP_GAP) |-> !O_PULSE)
		else $error("pulse emitted outside active period");
	a_start_joint: assert property ((ap_state_reg == AP_IDLE && run_q) |=>
		per_if.count == 32'h1 && fp_if.count == 32'h1)
		else $error("period counters did not start together");
	a_irq_period: assert property ((run_q && fp_if.match1) |=>
		irq_status_reg[`PDG_IRQ_PERIOD])
		else $error("full period did not raise interrupt status");
	a_min_phase: assert property ((pw_if.run && pw_if.clear) |->
		pw_if.count >= 32'(MIN_PHASE) - 32'h1)
		else $error("pulse phase shorter than the rate limit allows");
endmodule

// [tb/pdg_drive_model.sv]
// Behavioural motor drive that counts steps and measures phase widths
`timescale 1ns/10ps
module pdg_drive_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Drive inputs
	input wire logic i_pulse,
	input wire logic i_dir,
	// Observations
	output logic [31:0] o_steps,
	output logic [31:0] o_high_w,
	output logic [31:0] o_low_w,
	output logic o_dir_seen
);
	logic pulse_q;
	logic [31:0] run_len;

	// Width is counted in samples, so it is exact in system cycles
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pulse_q <= 1'b0;
			run_len <= 32'h0;
			o_steps <= 32'h0;
			o_high_w <= 32'h0;
			o_low_w <= 32'h0;
			o_dir_seen <= 1'b0;
		end else begin
			pulse_q <= i_pulse;
			run_len <= (i_pulse != pulse_q) ? 32'h1 : run_len + 32'h1;
			// A drive takes the direction level at the step edge
			if (i_pulse && !pulse_q) begin
				o_steps <= o_steps + 32'h1;
				o_dir_seen <= i_dir;
				o_low_w <= run_len;
			end
			if (!i_pulse && pulse_q) begin
				o_high_w <= run_len;
			end
		end
	end
endmodule

// [tb/pulse_direction_generator_tb.sv]
// Self-checking bench for the pulse and direction generator
`timescale 1ns/10ps
`include "pdg_defs.svh"
module pulse_direction_generator_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic trig = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, pulse, dir, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, steps, high_w, low_w;
	logic dir_seen;
	int n_mismatch = 0, checks = 0, seed = 32'h1ec51974;
	logic [31:0] rst_val [8] = '{32'h0, 32'(`PDG_RST_NUM),
		32'(`PDG_RST_HIGH), 32'(`PDG_RST_LOW), `PDG_RST_ACTIVE,
		`PDG_RST_PERIOD, 32'h0, 32'h0};

	always #10 clk = ~clk;

	pdg_top dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_TRIGGER(trig),
		.I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
		.O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb),
		.I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp),
		.O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
		.I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
		.O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
		.O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .O_PULSE(pulse),
		.O_DIR(dir), .O_IRQ(irq));

	pdg_drive_model drv (.i_clk(clk), .i_rst_n(rst_n), .i_pulse(pulse),
		.i_dir(dir), .o_steps(steps), .o_high_w(high_w), .o_low_w(low_w),
		.o_dir_seen(dir_seen));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] stretch(input logic [15:0] w);
		return (w < `PDG_MIN_PHASE_CYC) ? `PDG_MIN_PHASE_CYC : {16'h0, w};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw, w, b;
		@(posedge clk);
		aw = 1'b1;
		w = 1'b1;
		b = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b && n < 100) begin
			@(posedge clk);
			n++;
			aw = aw && !awready;
			w = w && !wready;
			b = bvalid;
			awvalid <= aw;
			wvalid <= w;
			bready <= !b;
		end
		chk("write response", {30'h0, er}, b ? {30'h0, bresp} : 32'h3);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ar, rv;
		@(posedge clk);
		ar = 1'b1;
		rv = 1'b0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rv && n < 100) begin
			@(posedge clk);
			n++;
			ar = ar && !arready;
			rv = rvalid;
			arvalid <= ar;
			rready <= !rv;
		end
		d = rdata;
		r = rresp;
		chk("read answered", 32'h1, {31'h0, rv});
	endtask

	task automatic setup_run(input logic [15:0] n, input logic [15:0] h,
		input logic [15:0] l, input logic d);
		wr(`PDG_OFS_NUM, {16'h0, n}, `PDG_RESP_OKAY);
		wr(`PDG_OFS_HIGH, {16'h0, h}, `PDG_RESP_OKAY);
		wr(`PDG_OFS_LOW, {16'h0, l}, `PDG_RESP_OKAY);
		wr(`PDG_OFS_ACTIVE, 32'd400, `PDG_RESP_OKAY);
		wr(`PDG_OFS_PERIOD, 32'd1000, `PDG_RESP_OKAY);
		wr(`PDG_OFS_CTRL, {29'h0, d, 2'b11}, `PDG_RESP_OKAY);
	endtask

	// Snapshot the step count half way through the period after an event
	task automatic mark(output logic [31:0] s);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2500) begin
			@(posedge clk);
			n++;
		end
		chk("period event", 32'h1, {31'h0, irq});
		wr(`PDG_OFS_IRQ_STAT, 32'h1, `PDG_RESP_OKAY);
		repeat (500) @(posedge clk);
		s = steps;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		logic [31:0] d, s0, s1;
		logic [1:0] r;
		logic [15:0] num, hw, lw;
		logic dr;
		int bad, n;
		repeat (5) @(posedge clk);
		chk("pulse in reset", 32'h0, {31'h0, pulse});
		chk("dir in reset", 32'h0, {31'h0, dir});
		chk("irq in reset", 32'h0, {31'h0, irq});
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4), d, r);
			chk("reset value", rst_val[i], d);
		end
		rd(8'h40, d, r);
		chk("unmapped data", 32'h0, d);
		chk("unmapped read response", {30'h0, `PDG_RESP_SLVERR}, {30'h0, r});
		wr(8'h44, 32'h5, `PDG_RESP_SLVERR);
		wr(`PDG_OFS_STATE, 32'hffff, `PDG_RESP_OKAY);
		wr(`PDG_OFS_IRQ_MASK, 32'h1, `PDG_RESP_OKAY);
		// First pass uses a width below the rate limit
		for (int it = 0; it < 3; it++) begin
			num = 16'd2 + 16'($unsigned($random(seed)) % 5);
			hw = (it == 0) ? 16'd2 : 16'd2 + 16'($unsigned($random(seed)) % 29);
			lw = 16'd2 + 16'($unsigned($random(seed)) % 29);
			dr = 1'($random(seed));
			setup_run(num, hw, lw, dr);
			mark(s0);
			mark(s1);
			chk("pulses per period", {16'h0, num}, s1 - s0);
			chk("high width", stretch(hw), high_w);
			chk("low width", stretch(lw), low_w);
			chk("dir at step", {31'h0, dr}, {31'h0, dir_seen});
			// Second pass stops by clearing enable, the others by run
			wr(`PDG_OFS_CTRL, {29'h0, dr, (it == 1) ? 2'b10 : 2'b01},
				`PDG_RESP_OKAY);
			repeat (2) @(posedge clk);
			s0 = steps;
			bad = 0;
			repeat (1100) begin
				@(posedge clk);
				if (pulse !== 1'b0)
					bad++;
			end
			chk("pulse while stopped", 32'h0, 32'(bad));
			chk("steps while stopped", s0, steps);
		end
		// Update mid-period with a trigger; direction must wait for the end
		setup_run(16'd3, 16'd8, 16'd9, 1'b1);
		mark(s0);
		rd(`PDG_OFS_STATE, d, r);
		chk("state in gap", {16'd3, 16'h0002}, d);
		wr(`PDG_OFS_NUM, 32'd5, `PDG_RESP_OKAY);
		wr(`PDG_OFS_CTRL, 32'h3, `PDG_RESP_OKAY);
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
		bad = 0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (irq !== 1'b1 && dir !== 1'b1)
				bad++;
		end while (irq !== 1'b1 && n < 1000);
		chk("dir held to period end", 32'h0, 32'(bad));
		mark(s1);
		chk("pulses after reload", 32'd5, s1 - s0);
		chk("dir after reload", 32'h0, {31'h0, dir_seen});
		chk("dir output", 32'h0, {31'h0, dir});
		wr(`PDG_OFS_IRQ_MASK, 32'h0, `PDG_RESP_OKAY);
		repeat (1100) @(posedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		rd(`PDG_OFS_IRQ_STAT, d, r);
		chk("status sticky", 32'h1, d & 32'h1);
		chk("reload status", 32'h2, d & 32'h2);
		wr(`PDG_OFS_IRQ_MASK, 32'h1, `PDG_RESP_OKAY);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(`PDG_OFS_IRQ_STAT, 32'h1, `PDG_RESP_OKAY);
		chk("irq cleared", 32'h0, {31'h0, irq});
		end_sim();
	end
endmodule
